// ### hdl/srbuf_top.sv
// Overview of operation
// - Transfers start only from an issued command.
// - Direction routes data out of or into memory.
// - Fixed count ends after exactly count elements.
// - Variable count ends on end flag or limit.
// - Elements use consecutive words from the base.
// - All memory traffic passes through stream fifos.
// - One wide row access per cycle, shared.
// - A transfer stays bound to one fifo.
// - Each client owns its own fifo group.
// - Each fifo keeps element order both ways.
// - Fifo must support the transfer direction.
// - Client lane width is a per-client parameter.
// - Memory banked per cluster, row aligned access.
// - Clusters, address generators, scalar unit are clients.
// - Cluster lanes put independently via lane steering; reads take the lowest clientTakeN lanes.
`default_nettype none
module srbuf_top #(
  parameter int NCL = srbuf_pkg::DEF_NCL,
  parameter int ROWS = srbuf_pkg::DEF_ROWS,
  parameter int W = srbuf_pkg::DEF_WORD_W,
  parameter int DEPTH = srbuf_pkg::DEF_DEPTH,
  parameter int NB = srbuf_pkg::DEF_BUFS_PER_CLIENT,
  parameter int CW = srbuf_pkg::DEF_COUNT_W,
  parameter int CLIENT_LANES [srbuf_pkg::NUM_CLIENTS] =
    '{srbuf_pkg::DEF_NCL, srbuf_pkg::DEF_LANES_AGEN, srbuf_pkg::DEF_LANES_SCALAR},
  parameter logic [srbuf_pkg::NUM_CLIENTS*NB-1:0] BUF_CAN_READ = srbuf_pkg::DEF_CAN_READ,
  parameter logic [srbuf_pkg::NUM_CLIENTS*NB-1:0] BUF_CAN_WRITE = srbuf_pkg::DEF_CAN_WRITE,
  localparam int NCLI = srbuf_pkg::NUM_CLIENTS,
  localparam int NBUF = NCLI * NB,
  localparam int AW = $clog2(NCL * ROWS),
  localparam int RW = $clog2(ROWS),
  localparam int PW = $clog2(DEPTH),
  localparam int QW = PW + 1,
  localparam int LW = $clog2(NCL + 1),
  localparam int BW = $clog2(NBUF),
  localparam int SW = $clog2(NB)
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cmdValid,
  input wire logic [srbuf_pkg::CLIENT_W-1:0] cmdClient,
  input wire logic cmdDir,
  input wire logic [AW-1:0] cmdBase,
  input wire logic [CW-1:0] cmdCount,
  input wire logic cmdVar,
  output logic cmdAck,
  output logic cmdErr,
  output logic [BW-1:0] cmdBuf,
  output logic doneValid,
  output logic [BW-1:0] doneBuf,
  output logic [CW-1:0] doneCount,
  output logic [NBUF-1:0] bufBusy,
  input wire logic [SW-1:0] clientSel [NCLI],
  input wire logic [LW-1:0] clientTakeN [NCLI],
  input wire logic [NCL-1:0] clientPut [NCLI],
  input wire logic [W-1:0] clientWrData [NCLI][NCL],
  input wire logic [NCLI-1:0] clientEos,
  output logic [W-1:0] clientRdData [NCLI][NCL],
  output logic [LW-1:0] clientRdCount [NCLI],
  output logic [LW-1:0] clientWrSpace [NCLI]
);
  // ****************************************************************
  // State
  // ****************************************************************
  srbuf_pkg::srbuf_state_t state [NBUF];
  srbuf_pkg::srbuf_state_t next_state [NBUF];
  logic [NBUF-1:0] dirW, next_dirW, varF, next_varF;
  logic [AW-1:0] addr [NBUF];
  logic [AW-1:0] next_addr [NBUF];
  logic [CW-1:0] remCore [NBUF];
  logic [CW-1:0] next_remCore [NBUF];
  logic [CW-1:0] remCli [NBUF];
  logic [CW-1:0] next_remCli [NBUF];
  logic [CW-1:0] orig [NBUF];
  logic [CW-1:0] next_orig [NBUF];
  logic [W-1:0] fifo [NBUF][DEPTH];
  logic [W-1:0] next_fifo [NBUF][DEPTH];
  logic [PW-1:0] rdP [NBUF];
  logic [PW-1:0] next_rdP [NBUF];
  logic [PW-1:0] wrP [NBUF];
  logic [PW-1:0] next_wrP [NBUF];
  logic [QW-1:0] cnt [NBUF];
  logic [QW-1:0] next_cnt [NBUF];
  logic [BW-1:0] rrPtr, next_rr;
  logic next_cmdAck, next_cmdErr, next_doneValid;
  logic [BW-1:0] next_cmdBuf, next_doneBuf;
  logic [CW-1:0] next_doneCount;
  logic [W-1:0] next_rdData [NCLI][NCL];
  logic [LW-1:0] next_rdCount [NCLI];
  logic [LW-1:0] next_wrSpace [NCLI];
  logic [W-1:0] mem [NCL][ROWS];
  logic [NCL-1:0] memWe;
  logic [W-1:0] memWd [NCL];
  logic [RW-1:0] memRow;
  logic gnt, found, got, any;
  int gb, b, n, lo, moveN;

  function automatic int imin(input int x, input int y);
    return (x < y) ? x : y;
  endfunction

  function automatic logic [PW-1:0] ptrAdd(input logic [PW-1:0] p, input int j);
    return PW'(int'(p) + j);
  endfunction

  function automatic logic canDir(input int bi, input logic dir);
    return dir ? BUF_CAN_WRITE[bi] : BUF_CAN_READ[bi];
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_state = state;
    next_dirW = dirW;
    next_varF = varF;
    next_addr = addr;
    next_remCore = remCore;
    next_remCli = remCli;
    next_orig = orig;
    next_fifo = fifo;
    next_rdP = rdP;
    next_wrP = wrP;
    next_cnt = cnt;
    next_rr = rrPtr;
    next_cmdAck = 1'b0;
    next_cmdErr = 1'b0;
    next_cmdBuf = cmdBuf;
    next_doneValid = 1'b0;
    next_doneBuf = doneBuf;
    next_doneCount = doneCount;
    memWe = '0;
    memWd = '{default: '0};
    memRow = '0;
    gnt = 1'b0;
    found = 1'b0;
    got = 1'b0;
    any = 1'b0;
    gb = 0;
    b = 0;
    n = 0;
    lo = 0;
    moveN = 0;
    // Round robin keeps one busy fifo from starving the single core port
    for (int i = 0; i < NBUF; i++) begin
      b = (int'(rrPtr) + i) % NBUF;
      if (!gnt && (state[b] == srbuf_pkg::ST_RUN || state[b] == srbuf_pkg::ST_FLUSH) &&
          (dirW[b] ? cnt[b] != '0 : (remCore[b] != '0 && int'(cnt[b]) < DEPTH))) begin
        gnt = 1'b1;
        gb = b;
      end
    end
    if (gnt) begin
      // A grant never crosses a row, so each bank sees at most one word
      lo = int'(addr[gb]) % NCL;
      moveN = imin(NCL - lo, dirW[gb] ? int'(cnt[gb]) :
                   imin(int'(remCore[gb]), DEPTH - int'(cnt[gb])));
      memRow = RW'(int'(addr[gb]) / NCL);
      for (int j = 0; j < NCL; j++) begin
        if (j < moveN) begin
          if (dirW[gb]) begin
            memWe[lo+j] = 1'b1;
            memWd[lo+j] = fifo[gb][ptrAdd(rdP[gb], j)];
          end else begin
            next_fifo[gb][ptrAdd(wrP[gb], j)] = mem[lo+j][memRow];
          end
        end
      end
      if (dirW[gb]) begin
        next_rdP[gb] = ptrAdd(rdP[gb], moveN);
        next_cnt[gb] = QW'(int'(cnt[gb]) - moveN);
      end else begin
        next_wrP[gb] = ptrAdd(wrP[gb], moveN);
        next_cnt[gb] = QW'(int'(cnt[gb]) + moveN);
        next_remCore[gb] = CW'(int'(remCore[gb]) - moveN);
      end
      next_addr[gb] = AW'(int'(addr[gb]) + moveN);
      next_rr = BW'((gb + 1) % NBUF);
    end
    // Client side, one selected fifo of each client's own group
    for (int c = 0; c < NCLI; c++) begin
      if (int'(clientSel[c]) < NB) begin
        b = c * NB + int'(clientSel[c]);
        if (state[b] == srbuf_pkg::ST_RUN && !dirW[b]) begin
          n = imin(imin(int'(clientTakeN[c]), CLIENT_LANES[c]),
                   imin(int'(cnt[b]), int'(remCli[b])));
          next_rdP[b] = ptrAdd(rdP[b], n);
          next_cnt[b] = QW'(int'(next_cnt[b]) - n);
          next_remCli[b] = CW'(int'(remCli[b]) - n);
          // Early end discards whatever was prefetched beyond the end
          if (next_remCli[b] == '0 || (clientEos[c] && varF[b])) begin
            next_state[b] = srbuf_pkg::ST_DONE;
            next_remCore[b] = '0;
            next_cnt[b] = '0;
            next_rdP[b] = next_wrP[b];
          end
        end else if (state[b] == srbuf_pkg::ST_RUN && dirW[b]) begin
          n = 0;
          for (int l = 0; l < NCL; l++) begin
            // Requesting lanes are packed in lane order into the fifo
            if (clientPut[c][l] && l < CLIENT_LANES[c] && n < DEPTH - int'(cnt[b]) &&
                n < int'(remCli[b])) begin
              next_fifo[b][ptrAdd(wrP[b], n)] = clientWrData[c][l];
              n = n + 1;
            end
          end
          next_wrP[b] = ptrAdd(wrP[b], n);
          next_cnt[b] = QW'(int'(next_cnt[b]) + n);
          next_remCli[b] = CW'(int'(remCli[b]) - n);
          if (next_remCli[b] == '0 || (clientEos[c] && varF[b])) begin
            next_state[b] = srbuf_pkg::ST_FLUSH;
          end
        end
      end
    end
    for (int k = 0; k < NBUF; k++) begin
      if (state[k] == srbuf_pkg::ST_FLUSH && next_cnt[k] == '0) begin
        next_state[k] = srbuf_pkg::ST_DONE;
      end
    end
    // One completion per cycle; others wait in the done state
    for (int k = 0; k < NBUF; k++) begin
      if (!found && state[k] == srbuf_pkg::ST_DONE) begin
        found = 1'b1;
        next_state[k] = srbuf_pkg::ST_IDLE;
        next_doneValid = 1'b1;
        next_doneBuf = BW'(k);
        next_doneCount = orig[k] - remCli[k];
      end
    end
    // Command allocation
    if (cmdValid && !cmdAck && !cmdErr) begin
      if (int'(cmdClient) < NCLI) begin
        for (int k = 0; k < NB; k++) begin
          b = int'(cmdClient) * NB + k;
          if (canDir(b, cmdDir)) begin
            any = 1'b1;
            if (!got && state[b] == srbuf_pkg::ST_IDLE) begin
              got = 1'b1;
              next_state[b] = (cmdCount == '0) ? srbuf_pkg::ST_DONE : srbuf_pkg::ST_RUN;
              next_dirW[b] = cmdDir;
              next_varF[b] = cmdVar;
              next_addr[b] = cmdBase;
              next_remCore[b] = (cmdDir == srbuf_pkg::DIR_WRITE) ? '0 : cmdCount;
              next_remCli[b] = cmdCount;
              next_orig[b] = cmdCount;
              next_cnt[b] = '0;
              next_rdP[b] = '0;
              next_wrP[b] = '0;
              next_cmdAck = 1'b1;
              next_cmdBuf = BW'(b);
            end
          end
        end
      end
      next_cmdErr = !any;
    end
    // Outputs describe the selected fifo as it stands after this edge
    for (int c = 0; c < NCLI; c++) begin
      b = c * NB + ((int'(clientSel[c]) < NB) ? int'(clientSel[c]) : 0);
      next_rdCount[c] = (next_state[b] == srbuf_pkg::ST_RUN && !next_dirW[b]) ?
        LW'(imin(imin(int'(next_cnt[b]), int'(next_remCli[b])), CLIENT_LANES[c])) : '0;
      next_wrSpace[c] = (next_state[b] == srbuf_pkg::ST_RUN && next_dirW[b]) ?
        LW'(imin(imin(DEPTH - int'(next_cnt[b]), int'(next_remCli[b])), CLIENT_LANES[c])) : '0;
      for (int l = 0; l < NCL; l++) begin
        next_rdData[c][l] = (l < CLIENT_LANES[c]) ? next_fifo[b][ptrAdd(next_rdP[b], l)] : '0;
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < NBUF; k++) begin
        state[k] <= srbuf_pkg::RESET_STATE;
        addr[k] <= '0;
        remCore[k] <= '0;
        remCli[k] <= '0;
        orig[k] <= '0;
        rdP[k] <= '0;
        wrP[k] <= '0;
        cnt[k] <= '0;
      end
      dirW <= '0;
      varF <= '0;
      rrPtr <= '0;
    end else begin
      state <= next_state;
      addr <= next_addr;
      remCore <= next_remCore;
      remCli <= next_remCli;
      orig <= next_orig;
      rdP <= next_rdP;
      wrP <= next_wrP;
      cnt <= next_cnt;
      dirW <= next_dirW;
      varF <= next_varF;
      rrPtr <= next_rr;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fifo <= '{default: '{default: '0}};
    end else begin
      fifo <= next_fifo;
    end
  end

  // Storage only, so it carries no reset
  always_ff @(posedge sys_clk) begin
    for (int k = 0; k < NCL; k++) begin
      if (memWe[k]) begin
        mem[k][memRow] <= memWd[k];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmdAck <= 1'b0;
      cmdErr <= 1'b0;
      cmdBuf <= '0;
      doneValid <= 1'b0;
      doneBuf <= '0;
      doneCount <= '0;
      bufBusy <= '0;
      clientRdData <= '{default: '{default: '0}};
      clientRdCount <= '{default: '0};
      clientWrSpace <= '{default: '0};
    end else begin
      cmdAck <= next_cmdAck;
      cmdErr <= next_cmdErr;
      cmdBuf <= next_cmdBuf;
      doneValid <= next_doneValid;
      doneBuf <= next_doneBuf;
      doneCount <= next_doneCount;
      for (int k = 0; k < NBUF; k++) begin
        bufBusy[k] <= (next_state[k] != srbuf_pkg::ST_IDLE);
      end
      clientRdData <= next_rdData;
      clientRdCount <= next_rdCount;
      clientWrSpace <= next_wrSpace;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic gntQ;
  int gbQ;
  logic [AW-1:0] addrExpQ;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gntQ <= 1'b0;
      gbQ <= 0;
      addrExpQ <= '0;
    end else begin
      gntQ <= gnt;
      gbQ <= gb;
      addrExpQ <= AW'(int'(addr[gb]) + moveN);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_ack_pulse: assert property (cmdAck |=> !cmdAck) else $error("ack longer than one cycle");
  a_group_owner: assert property (cmdAck |-> int'(cmdBuf) / NB == int'($past(cmdClient)))
    else $error("fifo outside client group");
  a_dir_support: assert property (cmdAck |-> canDir(int'(cmdBuf), $past(cmdDir)) && bufBusy[cmdBuf])
    else $error("fifo lacks direction");
  a_fixed_count: assert property (doneValid && !varF[doneBuf] |-> doneCount == orig[doneBuf])
    else $error("fixed transfer count wrong");
  a_var_limit: assert property (doneValid |-> doneCount <= orig[doneBuf])
    else $error("transfer exceeded limit");
  a_linear_addr: assert property (gntQ |-> addr[gbQ] == addrExpQ)
    else $error("address not sequential");
  a_core_width: assert property (gnt |-> moveN >= 1 && moveN <= NCL && cnt[gb] <= QW'(DEPTH))
    else $error("core move out of range");
  a_core_owner: assert property (gnt |-> state[gb] == srbuf_pkg::ST_RUN || state[gb] == srbuf_pkg::ST_FLUSH)
    else $error("core access without transfer");
  a_release_buf: assert property (doneValid |-> !bufBusy[doneBuf])
    else $error("fifo not released");

  c_read_done: cover property (cmdAck && !dirW[cmdBuf] ##[1:60] doneValid);
  c_early_end: cover property (doneValid && varF[doneBuf] && doneCount < orig[doneBuf]);
  c_write_flush: cover property (gnt && dirW[gb] && state[gb] == srbuf_pkg::ST_FLUSH);
endmodule // srbuf_top
`default_nettype wire

// ### hdl/srbuf_pkg.sv
`default_nettype none
package srbuf_pkg;
  // ****************************************************************
  // Client identities and transfer directions
  // ****************************************************************
  localparam int NUM_CLIENTS = 3;
  localparam int CLIENT_W = 2;
  localparam logic [CLIENT_W-1:0] CLIENT_CLUSTER = 2'h0;
  localparam logic [CLIENT_W-1:0] CLIENT_AGEN = 2'h1;
  localparam logic [CLIENT_W-1:0] CLIENT_SCALAR = 2'h2;
  // Read moves words out of the core memory, write moves them in
  localparam logic DIR_READ = 1'h0;
  localparam logic DIR_WRITE = 1'h1;

  // ****************************************************************
  // Structural defaults
  // ****************************************************************
  localparam int DEF_NCL = 4;
  localparam int DEF_ROWS = 16;
  localparam int DEF_WORD_W = 32;
  localparam int DEF_DEPTH = 8;
  localparam int DEF_BUFS_PER_CLIENT = 2;
  localparam int DEF_COUNT_W = 8;
  localparam int DEF_LANES_AGEN = 2;
  localparam int DEF_LANES_SCALAR = 1;
  // Per buffer capability, buffer index = client * buffers per client + slot
  localparam logic [5:0] DEF_CAN_READ = 6'h3f;
  localparam logic [5:0] DEF_CAN_WRITE = 6'h15;

  // ****************************************************************
  // Buffer life cycle
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_FLUSH = 2'b10,
    ST_DONE = 2'b11
  } srbuf_state_t;
  localparam srbuf_state_t RESET_STATE = ST_IDLE;
endpackage
`default_nettype wire

// ### hdl/srbuf_unused_guard.sv
`default_nettype none
`default_nettype wire

// ### tb/srbuf_client_model.sv
`default_nettype none
module srbuf_client_model (
  input wire logic sys_clk,
  input wire logic [31:0] clientRdData [3][4],
  input wire logic [2:0] clientRdCount [3],
  input wire logic [2:0] clientWrSpace [3],
  output logic [0:0] clientSel [3],
  output logic [2:0] clientTakeN [3],
  output logic [3:0] clientPut [3],
  output logic [31:0] clientWrData [3][4],
  output logic [2:0] clientEos
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Client state, set by the bench between transfers
  // ****************************************************************
  int seed = 32'hf77d;
  logic [0:0] sel [3];
  logic [31:0] wrQ [3][$];
  logic [31:0] rdQ [3][$];
  int eosAt [3];
  int rxCnt [3];
  int lanes [3] = '{4, 2, 1};
  // ****************************************************************
  // Per cycle client behaviour, randomly stalling on both sides
  // ****************************************************************
  initial begin
    for (int c = 0; c < 3; c++) begin
      sel[c] = 1'h0;
      eosAt[c] = 1000;
      rxCnt[c] = 0;
    end
    forever begin
      for (int c = 0; c < 3; c++) begin
        int k;
        int put;
        logic [3:0] pm;
        logic [31:0] wd [4];
        clientSel[c] = sel[c];
        clientEos[c] = (rxCnt[c] >= eosAt[c]);
        k = (($random(seed) & 1) != 0) ? 0 : int'(clientRdCount[c]);
        if (eosAt[c] - rxCnt[c] < k) k = eosAt[c] - rxCnt[c];
        clientTakeN[c] = k[2:0];
        for (int l = 0; l < k; l++) begin
          rdQ[c].push_back(clientRdData[c][l]);
          rxCnt[c]++;
        end
        k = (($random(seed) & 1) != 0) ? 0 : int'(clientWrSpace[c]);
        if (k > lanes[c]) k = lanes[c];
        if (k > wrQ[c].size()) k = wrQ[c].size();
        if (eosAt[c] - rxCnt[c] < k) k = eosAt[c] - rxCnt[c];
        pm = 4'h0;
        put = 0;
        // Set lanes are scattered at random, so lane packing is exercised
        for (int l = 0; l < 4; l++) begin
          if (l < lanes[c] && put < k &&
              ((($random(seed) & 1) != 0) || lanes[c] - l <= k - put)) begin
            pm[l] = 1'b1;
            wd[l] = wrQ[c].pop_front();
            put++;
          end else begin
            // Unused lanes carry noise so stale data can never pass for a put
            wd[l] = $random(seed);
          end
        end
        rxCnt[c] += put;
        clientPut[c] = pm;
        clientWrData[c] = wd;
      end
      @(negedge sys_clk);
    end
  end
endmodule // srbuf_client_model
`default_nettype wire

// ### tb/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst, cmdValid, cmdDir, cmdVar, cmdAck, cmdErr, doneValid;
  logic [1:0] cmdClient;
  logic [5:0] cmdBase, bufBusy;
  logic [7:0] cmdCount, doneCount;
  logic [2:0] cmdBuf, doneBuf, clientEos;
  logic [0:0] clientSel [3];
  logic [2:0] clientTakeN [3];
  logic [3:0] clientPut [3];
  logic [31:0] clientWrData [3][4];
  logic [31:0] clientRdData [3][4];
  logic [2:0] clientRdCount [3];
  logic [2:0] clientWrSpace [3];
  logic [31:0] expMem [64];
  int fails = 0;
  int samples_checked = 0;
  int seed = 32'hf77d;

  srbuf_top i_srbuf_top (.sys_clk(sys_clk), .rst(rst), .cmdValid(cmdValid), .cmdClient(cmdClient),
    .cmdDir(cmdDir), .cmdBase(cmdBase), .cmdCount(cmdCount), .cmdVar(cmdVar), .cmdAck(cmdAck),
    .cmdErr(cmdErr), .cmdBuf(cmdBuf), .doneValid(doneValid), .doneBuf(doneBuf), .doneCount(doneCount),
    .bufBusy(bufBusy), .clientSel(clientSel), .clientTakeN(clientTakeN), .clientPut(clientPut),
    .clientWrData(clientWrData), .clientEos(clientEos), .clientRdData(clientRdData),
    .clientRdCount(clientRdCount), .clientWrSpace(clientWrSpace));
  srbuf_client_model i_srbuf_client_model (.sys_clk(sys_clk), .clientRdData(clientRdData),
    .clientRdCount(clientRdCount), .clientWrSpace(clientWrSpace), .clientSel(clientSel),
    .clientTakeN(clientTakeN), .clientPut(clientPut), .clientWrData(clientWrData), .clientEos(clientEos));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ****************************************************************
  // Comparison and closing
  // ****************************************************************
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_ctl(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Command issue and full transfer with reference memory
  // ****************************************************************
  task automatic issue(input logic [1:0] c, input logic d, input int base, input int n, input logic v,
                       output logic [2:0] b);
    int t;
    cmdClient = c;
    cmdDir = d;
    cmdBase = base[5:0];
    cmdCount = n[7:0];
    cmdVar = v;
    cmdValid = 1'b1;
    t = 0;
    do begin
      @(negedge sys_clk);
      t++;
    end while (cmdAck !== 1'b1 && cmdErr !== 1'b1 && t < 200);
    cmdValid = 1'b0;
    b = cmdBuf;
  endtask

  task automatic xfer(input int c, input logic d, input int base, input int n, input logic v, input int eosAt);
    logic [2:0] b;
    int t;
    int m;
    m = (v && eosAt < n) ? eosAt : n;
    i_srbuf_client_model.eosAt[c] = v ? eosAt : 1000;
    i_srbuf_client_model.rxCnt[c] = 0;
    i_srbuf_client_model.rdQ[c].delete();
    if (d == srbuf_pkg::DIR_WRITE) begin
      for (int i = 0; i < m; i++) begin
        expMem[base + i] = $random(seed);
        i_srbuf_client_model.wrQ[c].push_back(expMem[base + i]);
      end
    end
    issue(c[1:0], d, base, n, v, b);
    cmp_ctl({7'h0, cmdAck}, 8'h1);
    cmp_ctl({6'h0, b[2:1]}, c[7:0]);
    if (d == srbuf_pkg::DIR_WRITE) cmp_ctl({7'h0, b[0]}, 8'h0);
    cmp_ctl({7'h0, bufBusy[b]}, 8'h1);
    i_srbuf_client_model.sel[c] = b[0];
    t = 0;
    while (doneValid !== 1'b1 && t < 3000) begin
      @(negedge sys_clk);
      t++;
    end
    cmp_ctl({7'h0, doneValid}, 8'h1);
    cmp_ctl({5'h0, doneBuf}, {5'h0, b});
    cmp_ctl(doneCount, m[7:0]);
    cmp_ctl({7'h0, bufBusy[b]}, 8'h0);
    if (d == srbuf_pkg::DIR_READ) begin
      cmp_ctl(8'(i_srbuf_client_model.rdQ[c].size()), m[7:0]);
      for (int i = 0; i < m && i < i_srbuf_client_model.rdQ[c].size(); i++) begin
        cmp_word(i_srbuf_client_model.rdQ[c][i], expMem[base + i]);
      end
    end
    i_srbuf_client_model.eosAt[c] = 1000;
    @(negedge sys_clk);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    int n;
    int base;
    logic [2:0] b;
    rst = 1'b1;
    cmdValid = 1'b0;
    cmdClient = 2'h0;
    cmdDir = 1'b0;
    cmdBase = 6'h0;
    cmdCount = 8'h0;
    cmdVar = 1'b0;
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    issue(2'h3, srbuf_pkg::DIR_READ, 0, 1, 1'b0, b);
    cmp_ctl({6'h0, cmdErr, cmdAck}, 8'h2);
    @(negedge sys_clk);
    xfer(2, srbuf_pkg::DIR_READ, 5, 0, 1'b0, 0);
    // Each client writes, the next one reads back, so every group is crossed
    for (int c = 0; c < 3; c++) begin
      n = 1 + ($unsigned($random(seed)) % 20);
      base = $unsigned($random(seed)) % (64 - n);
      xfer(c, srbuf_pkg::DIR_WRITE, base, n, 1'b0, 0);
      xfer((c + 1) % 3, srbuf_pkg::DIR_READ, base, n, 1'b0, 0);
    end
    xfer(0, srbuf_pkg::DIR_WRITE, 40, 12, 1'b0, 0);
    xfer(0, srbuf_pkg::DIR_READ, 40, 12, 1'b1, 5);
    xfer(1, srbuf_pkg::DIR_READ, 40, 3, 1'b1, 1000);
    xfer(2, srbuf_pkg::DIR_WRITE, 20, 9, 1'b1, 4);
    xfer(1, srbuf_pkg::DIR_READ, 20, 4, 1'b0, 0);
    complete_run();
  end

  // Generous bound, the whole sequence needs only a few hundred cycles
  initial begin
    #(20000 * 5);
    fails++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
